// File: shared/clk_sync_if.sv
// pins between the host controller and the clock distribution device
`timescale 1ns/1ns
`default_nettype none
interface clk_sync_if;
    logic sync_n;
    logic reset_n;
    logic sleep_pin_n;
    logic cfg_src;
    logic sclk;
    logic csb;
    logic sdi;
    modport dev  (input sync_n, reset_n, sleep_pin_n, cfg_src, sclk, csb, sdi);
    modport host (output sync_n, reset_n, sleep_pin_n, cfg_src, sclk, csb, sdi);
endinterface : clk_sync_if
`default_nettype wire

// File: shared/clk_sync_pkg.sv
// constants shared by the output sync and reset control ends
package clk_sync_pkg;
    localparam int          NUM_CH         = 4;
    localparam int          OUT_PER_CH     = 3;
    localparam int          NUM_OUT        = 12;
    localparam int          FRAME_BITS     = 24;
    // register addresses
    localparam logic [15:0] ADDR_SPCFG     = 16'h0000;
    localparam logic [15:0] ADDR_OUT_BASE  = 16'h00F0;
    localparam logic [15:0] ADDR_OUT_LAST  = 16'h00FB;
    localparam logic [15:0] ADDR_CH_BASE   = 16'h0190;
    localparam logic [15:0] ADDR_DIST      = 16'h0230;
    localparam logic [15:0] ADDR_UPDATE    = 16'h0232;
    // field positions
    localparam int          SP_SRST_LO     = 2;
    localparam int          SP_SRST_HI     = 5;
    localparam int          DIST_SOFT_SYNC = 0;
    localparam int          DIST_PD        = 1;
    localparam int          UPD_XFER       = 0;
    localparam int          OUT_PD         = 0;
    localparam int          OUT_SWING_LO   = 1;
    localparam int          OUT_CMOS       = 3;
    localparam int          OUT_INV_A      = 4;
    localparam int          OUT_EN_A       = 5;
    localparam int          OUT_EN_B       = 6;
    localparam int          OUT_INV_B      = 7;
    localparam int          CH_DLY_LO      = 0;
    localparam int          CH_ILH         = 4;
    localparam int          CH_EXCL        = 5;
    localparam int          CH_PD          = 6;
    // reset values
    localparam logic [7:0]  SPCFG_RST      = 8'h00;
    localparam logic [7:0]  OUT_CFG_RST    = 8'h02;
    localparam logic [7:0]  CH_DIV_RST     = 8'h00;
    localparam logic [7:0]  CH_CTL_RST     = 8'h00;
    localparam logic [7:0]  DIST_RST       = 8'h00;
    // timing
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          SYNC_PIPE_CYC  = 15;
    localparam int          POR_SYNC_MS    = 50;
    localparam int          POR_SYNC_CYC   = CLK_HZ / 1000 * POR_SYNC_MS;
    localparam int          HW_NVM_MS      = 20;
    localparam int          HW_NVM_CYC     = CLK_HZ / 1000 * HW_NVM_MS;
    localparam int          HW_DEF_US      = 2;
    localparam int          HW_DEF_CYC     = CLK_HZ / 1_000_000 * HW_DEF_US;
    localparam int          SCLK_HALF_CYC  = 2;
    localparam int          PIN_LOW_CYC    = 4;
endpackage : clk_sync_pkg

// File: sim/output_sync_and_reset_control_bench.sv
// bench joining host and device ends with a register model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module output_sync_and_reset_control_bench;
    localparam logic [7:0] NVM = 8'h04;
    logic clk, rst_b, wr_valid, wr_ready, sync_req, reset_req, sleep_req, cfg_src_sel, cal_busy;
    logic [15:0] wr_addr;
    logic [7:0] wr_data, s, d, m [12];
    logic [11:0] diff_on, safe_pd, cmos_a_oe, cmos_b_oe;
    logic [11:0] diff_q, cmos_a, cmos_b, q;
    logic [11:0][1:0] swing;
    logic total_pd, sync_active;
    int num_errors, checked, n;
    clk_sync_if bus();
    sync_host sync_host_i (.clk(clk), .rst_b(rst_b), .pins(bus.host), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready), .sync_req(sync_req),
        .reset_req(reset_req), .sleep_req(sleep_req), .cfg_src_sel(cfg_src_sel));
    sync_dev #(.POR_CYC(50), .HW_NVM_CYC(30), .NVM_OUT(NVM)) sync_dev_i (.clk(clk),
        .rst_b(rst_b), .pins(bus.dev), .cal_busy(cal_busy), .diff_q(diff_q), .diff_on(diff_on),
        .safe_pd(safe_pd), .total_pd(total_pd), .swing(swing), .cmos_a(cmos_a), .cmos_b(cmos_b),
        .cmos_a_oe(cmos_a_oe), .cmos_b_oe(cmos_b_oe), .sync_active(sync_active));
    sync_pins_chk sync_pins_chk_i (.clk(clk), .rst_b(rst_b), .sync_n(bus.sync_n),
        .reset_n(bus.reset_n), .sclk(bus.sclk), .csb(bus.csb), .sdi(bus.sdi));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic end_of_test;
        if (num_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        while (wr_ready !== 1'b1) @(negedge clk);
        wr_valid = 1'b1;
        wr_addr = a;
        wr_data = v;
        @(negedge clk) wr_valid = 1'b0;
        do @(negedge clk); while (wr_ready !== 1'b1);
        repeat (6) @(negedge clk);
    endtask : wr
    task automatic wait_sa(input logic v, input int lim);
        n = 0;
        while (sync_active !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        `CHK(sync_active, v)
    endtask : wait_sa
    task automatic pulse(input logic rst_pin);
        @(negedge clk) if (rst_pin) reset_req = 1'b1; else sync_req = 1'b1;
        @(negedge clk) {sync_req, reset_req} = 2'h0;
    endtask : pulse
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
    initial begin
        {rst_b, wr_valid, sync_req, reset_req, sleep_req, cfg_src_sel, cal_busy} = 7'h00;
        {wr_addr, wr_data, num_errors, checked} = '0;
        s = 8'h5B;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        foreach (m[i]) m[i] = clk_sync_pkg::OUT_CFG_RST;
        wait_sa(1'b0, 400);
        for (int k = 0; k < 24; k++) begin
            s = lfsr(s);
            d = s & 8'hFE;
            m[k % 12] = {d[7], (d[3] && !m[k % 12][3]) ? 2'h3 : d[6:5], d[4:0]};
            wr(clk_sync_pkg::ADDR_OUT_BASE + 16'(k % 12), d);
            d = m[k % 12];
            `CHK(swing[k % 12], d[2:1])
            `CHK(cmos_a_oe[k % 12], d[3] & d[5])
            `CHK(cmos_b_oe[k % 12], d[3] & d[6])
            `CHK(diff_on[k % 12], !d[3])
        end
        wr(clk_sync_pkg::ADDR_OUT_BASE, 8'h01);
        `CHK({safe_pd[0], diff_on[0]}, 2'h2)
        wr(clk_sync_pkg::ADDR_DIST, 8'h01);
        `CHK(sync_active, 1'b0)
        wr(clk_sync_pkg::ADDR_UPDATE, 8'h01);
        `CHK(sync_active, 1'b1)
        wr(clk_sync_pkg::ADDR_DIST, 8'h02);
        wr(clk_sync_pkg::ADDR_UPDATE, 8'h01);
        `CHK(total_pd, 1'b1)
        wr(clk_sync_pkg::ADDR_DIST, 8'h00);
        wr(clk_sync_pkg::ADDR_UPDATE, 8'h01);
        wait_sa(1'b0, 100);
        `CHK(total_pd, 1'b0)
        pulse(1'b0);
        repeat (3) @(negedge clk);
        `CHK(sync_active, 1'b1)
        while (bus.sync_n !== 1'b1 && n < 999) @(negedge clk);
        wait_sa(1'b0, 100);
        `CHK(n >= 15 && n <= 20, 1'b1)
        sleep_req = 1'b1;
        repeat (6) @(negedge clk);
        `CHK({sync_active, safe_pd}, 13'h1FFF)
        `CHK({diff_q, cmos_a, cmos_b, cmos_a_oe, cmos_b_oe}, 60'h0)
        sleep_req = 1'b0;
        wait_sa(1'b0, 100);
        cal_busy = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(sync_active, 1'b1)
        cal_busy = 1'b0;
        wait_sa(1'b0, 100);
        wr(clk_sync_pkg::ADDR_SPCFG, 8'h24);
        wait_sa(1'b0, 200);
        foreach (m[i]) `CHK(swing[i], clk_sync_pkg::OUT_CFG_RST[2:1])
        wr(clk_sync_pkg::ADDR_CH_BASE + 16'h0001, 8'h20);
        cal_busy = 1'b1;
        repeat (4) @(negedge clk);
        q = diff_q;
        @(negedge clk);
        `CHK(diff_q, {9'h000, ~q[2:0]})
        cal_busy = 1'b0;
        wait_sa(1'b0, 100);
        repeat (3) @(negedge clk);
        q = diff_q;
        @(negedge clk);
        `CHK(diff_q, ~q)
        cfg_src_sel = 1'b1;
        pulse(1'b1);
        repeat (3) @(negedge clk);
        `CHK(sync_active, 1'b1)
        repeat (4) @(negedge clk);
        `CHK(diff_q, 12'h000)
        wait_sa(1'b0, 300);
        `CHK(n >= 30, 1'b1)
        foreach (m[i]) `CHK(swing[i], NVM[2:1])
        end_of_test;
    end
endmodule : output_sync_and_reset_control_bench
`default_nettype wire

// File: sim/sync_pins_chk.sv
// assertions on the pins between host and device
`timescale 1ns/1ns
`default_nettype none
module sync_pins_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sync_n,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic csb,
    input wire logic sdi
);
    logic       sclk_q;
    logic [4:0] cnt;
    // counts serial clock rises inside one frame
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
        if (!rst_b || csb)
            cnt <= 5'h00;
        else if (sclk && !sclk_q)
            cnt <= cnt + 5'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_pins_idle: assert property ($rose(rst_b) |-> csb && !sclk && sync_n && reset_n)
        else $error("pins not idle after reset");
    a_sync_pulse: assert property ($fell(sync_n) |-> !sync_n [*4] ##1 sync_n)
        else $error("sync pulse length wrong");
    a_reset_pulse: assert property ($fell(reset_n) |-> !reset_n [*4] ##1 reset_n)
        else $error("reset pulse length wrong");
    a_sclk_half: assert property ($rose(sclk) |-> ##1 sclk ##1 !sclk)
        else $error("serial clock high time wrong");
    a_sdi_stable: assert property (sclk && !csb |-> $stable(sdi))
        else $error("serial data moved while clock high");
    a_frame_len: assert property ($rose(csb) |-> cnt == 5'h18)
        else $error("frame bit count wrong");
    a_trail_pulse: assert property ($rose(csb) |-> ##[1:6] sclk)
        else $error("no trailing serial clock");
    a_csb_hold: assert property ($fell(csb) |-> !sclk ##1 !csb [*8])
        else $error("frame ended early");
    c_frame: cover property ($rose(csb));
    c_sync: cover property ($rose(sync_n));
    c_reset: cover property ($rose(reset_n));
endmodule : sync_pins_chk
`default_nettype wire

// File: verilog/chan_div.sv
// one channel divider with static preset and coarse delay restart
`timescale 1ns/1ns
`default_nettype none
module chan_div (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       hold,
    input  wire logic       pd,
    input  wire logic [3:0] n_hi,
    input  wire logic [3:0] m_lo,
    input  wire logic       initial_level_high,
    input  wire logic [3:0] coarse_delay_field,
    output logic            lvl_r
);
    logic [5:0] cnt_r;
    logic       run_r;
    logic [5:0] dly;

    // m_lo holds low cycles minus one, so the weighted delay adds m_lo plus two; reaches 32
    always_comb begin
        if (!initial_level_high) begin
            dly = {2'b00, coarse_delay_field};
        end else begin
            dly = 6'({2'b00, coarse_delay_field} + {2'b00, m_lo} + 6'h02);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || pd) begin
            lvl_r <= 1'b0;
            cnt_r <= 6'h00;
            run_r <= 1'b0;
        end else if (hold) begin
            lvl_r <= initial_level_high;
            cnt_r <= dly;
            run_r <= 1'b0;
        end else if (!run_r) begin
            if (cnt_r == 6'h00) begin
                run_r <= 1'b1;
                lvl_r <= 1'b1;
                cnt_r <= {2'b00, n_hi};
            end else begin
                cnt_r <= cnt_r - 6'h01;
            end
        end else if (cnt_r == 6'h00) begin
            lvl_r <= ~lvl_r;
            cnt_r <= lvl_r ? {2'b00, m_lo} : {2'b00, n_hi};
        end else begin
            cnt_r <= cnt_r - 6'h01;
        end
    end
endmodule : chan_div
`default_nettype wire

// File: verilog/sync_dev.sv
// device end: serial registers, reset sequencing, sync and output drivers
`timescale 1ns/1ns
`default_nettype none
module sync_dev #(
    parameter int         POR_CYC    = clk_sync_pkg::POR_SYNC_CYC,
    parameter int         HW_NVM_CYC = clk_sync_pkg::HW_NVM_CYC,
    parameter logic [7:0] NVM_OUT    = 8'h0A,
    parameter logic [7:0] NVM_DIV    = 8'h11,
    parameter logic [7:0] NVM_CTL    = 8'h00
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    clk_sync_if.dev           pins,
    input  wire logic         cal_busy,
    output logic [11:0]       diff_q,
    output logic [11:0]       diff_on,
    output logic [11:0]       safe_pd,
    output logic              total_pd,
    output logic [11:0][1:0]  swing,
    output logic [11:0]       cmos_a,
    output logic [11:0]       cmos_b,
    output logic [11:0]       cmos_a_oe,
    output logic [11:0]       cmos_b_oe,
    output logic              sync_active
);
    localparam int WAIT_W = $clog2(POR_CYC + HW_NVM_CYC + 2);
    typedef enum logic [1:0] {ST_POR, ST_HWRST, ST_RUN} seq_t;

    // 0 sync, 1 reset, 2 sleep, 3 cfg_src, 4 sclk, 5 csb, 6 sdi
    logic [6:0]        pin_m_r;
    logic [6:0]        pin_s_r;
    logic              sclk_d_r;
    logic              sync_d_r;
    logic              sclk_rise;
    logic [23:0]       shift_r;
    logic [4:0]        bit_cnt_r;
    logic              wr_stb_r;
    logic [15:0]       wr_addr_r;
    logic [7:0]        wr_data_r;
    logic [7:0]        spcfg_r;
    logic              srst_r;
    logic [7:0]        out_cfg_r [12];
    logic [7:0]        ch_div_r  [4];
    logic [7:0]        ch_ctl_r  [4];
    logic [7:0]        dist_stage_r;
    logic [7:0]        dist_act_r;
    seq_t              seq_r;
    logic [WAIT_W-1:0] wait_r;
    logic              restore;
    logic              hold_lvl;
    logic [4:0]        pipe_r;
    logic              hold_r;
    logic [3:0]        ch_lvl;

    // every pin crosses two flops before use
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_m_r  <= 7'h3F;
            pin_s_r  <= 7'h3F;
            sclk_d_r <= 1'b1;
            sync_d_r <= 1'b1;
        end else begin
            pin_m_r  <= {pins.sdi, pins.csb, pins.sclk, pins.cfg_src,
                         pins.sleep_pin_n, pins.reset_n, pins.sync_n};
            pin_s_r  <= pin_m_r;
            sclk_d_r <= pin_s_r[4];
            sync_d_r <= pin_s_r[0];
        end
    end
    assign sclk_rise = pin_s_r[4] & ~sclk_d_r;

    // serial frame: 16 address bits then 8 data bits, msb first
    always_ff @(posedge clk) begin
        if (!rst_b || pin_s_r[5]) begin
            bit_cnt_r <= 5'h00;
            shift_r   <= 24'h000000;
            wr_stb_r  <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            if (sclk_rise) begin
                shift_r   <= {shift_r[22:0], pin_s_r[6]};
                bit_cnt_r <= (bit_cnt_r == 5'(clk_sync_pkg::FRAME_BITS - 1)) ? 5'h00
                                                                              : bit_cnt_r + 5'h01;
                wr_stb_r  <= (bit_cnt_r == 5'(clk_sync_pkg::FRAME_BITS - 1));
            end
        end
    end
    assign wr_addr_r = shift_r[23:8];
    assign wr_data_r = shift_r[7:0];

    // config register keeps its value; the reset bits clear on the next serial clock rise, and only when both were written high
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            spcfg_r <= clk_sync_pkg::SPCFG_RST;
            srst_r  <= 1'b0;
        end else if (wr_stb_r && wr_addr_r == clk_sync_pkg::ADDR_SPCFG) begin
            spcfg_r <= wr_data_r;
            srst_r  <= wr_data_r[clk_sync_pkg::SP_SRST_LO]
                     & wr_data_r[clk_sync_pkg::SP_SRST_HI];
        end else if (srst_r && sclk_rise) begin
            srst_r  <= 1'b0;
            spcfg_r[clk_sync_pkg::SP_SRST_LO] <= 1'b0;
            spcfg_r[clk_sync_pkg::SP_SRST_HI] <= 1'b0;
        end
    end

    assign restore = (seq_r != ST_RUN) | srst_r;

    // per output driver configuration
    always_ff @(posedge clk) begin
        for (int i = 0; i < clk_sync_pkg::NUM_OUT; i++) begin
            if (!rst_b) begin
                out_cfg_r[i] <= clk_sync_pkg::OUT_CFG_RST;
            end else if (restore) begin
                out_cfg_r[i] <= pin_s_r[3] ? NVM_OUT : clk_sync_pkg::OUT_CFG_RST;
            end else if (wr_stb_r && wr_addr_r == clk_sync_pkg::ADDR_OUT_BASE + 16'(i)) begin
                out_cfg_r[i] <= wr_data_r;
                if (wr_data_r[clk_sync_pkg::OUT_CMOS] && !out_cfg_r[i][clk_sync_pkg::OUT_CMOS]) begin
                    out_cfg_r[i][clk_sync_pkg::OUT_EN_B:clk_sync_pkg::OUT_EN_A] <= 2'b11;
                end
            end
        end
    end

    // per channel divider and control, two addresses per channel
    always_ff @(posedge clk) begin
        for (int c = 0; c < clk_sync_pkg::NUM_CH; c++) begin
            if (!rst_b) begin
                ch_div_r[c] <= clk_sync_pkg::CH_DIV_RST;
                ch_ctl_r[c] <= clk_sync_pkg::CH_CTL_RST;
            end else if (restore) begin
                ch_div_r[c] <= pin_s_r[3] ? NVM_DIV : clk_sync_pkg::CH_DIV_RST;
                ch_ctl_r[c] <= pin_s_r[3] ? NVM_CTL : clk_sync_pkg::CH_CTL_RST;
            end else if (wr_stb_r) begin
                if (wr_addr_r == clk_sync_pkg::ADDR_CH_BASE + 16'(2 * c)) begin
                    ch_div_r[c] <= wr_data_r;
                end
                if (wr_addr_r == clk_sync_pkg::ADDR_CH_BASE + 16'(2 * c + 1)) begin
                    ch_ctl_r[c] <= wr_data_r;
                end
            end
        end
    end

    // distribution register is staged and takes effect on update
    always_ff @(posedge clk) begin
        if (!rst_b || restore) begin
            dist_stage_r <= clk_sync_pkg::DIST_RST;
            dist_act_r   <= clk_sync_pkg::DIST_RST;
        end else if (wr_stb_r && wr_addr_r == clk_sync_pkg::ADDR_DIST) begin
            dist_stage_r <= wr_data_r;
        end else if (wr_stb_r && wr_addr_r == clk_sync_pkg::ADDR_UPDATE
                     && wr_data_r[clk_sync_pkg::UPD_XFER]) begin
            dist_act_r   <= dist_stage_r;
        end
    end

    // power-on wait, hardware reset wait
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            seq_r  <= ST_POR;
            wait_r <= WAIT_W'(POR_CYC);
        end else if (!pin_s_r[1]) begin
            seq_r  <= ST_HWRST;
            wait_r <= pin_s_r[3] ? WAIT_W'(HW_NVM_CYC)
                                 : WAIT_W'(clk_sync_pkg::HW_DEF_CYC);
        end else if (seq_r != ST_RUN) begin
            if (wait_r == '0) begin
                seq_r <= ST_RUN;
            end else begin
                wait_r <= wait_r - WAIT_W'(1);
            end
        end
    end

    // any source holds sync; release runs the restart pipeline
    assign hold_lvl = ~pin_s_r[0] | ~sync_d_r
                    | dist_act_r[clk_sync_pkg::DIST_SOFT_SYNC]
                    | dist_act_r[clk_sync_pkg::DIST_PD] | srst_r
                    | ~pin_s_r[2] | ~pin_s_r[1]
                    | cal_busy
                    | (seq_r != ST_RUN);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pipe_r <= 5'(clk_sync_pkg::SYNC_PIPE_CYC);
            hold_r <= 1'b1;
        end else if (hold_lvl) begin
            pipe_r <= 5'(clk_sync_pkg::SYNC_PIPE_CYC);
            hold_r <= 1'b1;
        end else if (pipe_r != 5'h00) begin
            pipe_r <= pipe_r - 5'h01;
        end else begin
            hold_r <= 1'b0;
        end
    end
    assign sync_active = hold_r;

    genvar g;
    generate
        for (g = 0; g < clk_sync_pkg::NUM_CH; g++) begin : g_ch
            chan_div u_div (
                .clk                (clk),
                .rst_b              (rst_b),
                .hold               (hold_r & ~ch_ctl_r[g][clk_sync_pkg::CH_EXCL]),
                .pd                 (ch_ctl_r[g][clk_sync_pkg::CH_PD] | ~pin_s_r[2]),
                .n_hi               (ch_div_r[g][3:0]),
                .m_lo               (ch_div_r[g][7:4]),
                .initial_level_high (ch_ctl_r[g][clk_sync_pkg::CH_ILH]),
                .coarse_delay_field (ch_ctl_r[g][clk_sync_pkg::CH_DLY_LO +: 4]),
                .lvl_r              (ch_lvl[g])
            );
        end
        for (g = 0; g < clk_sync_pkg::NUM_OUT; g++) begin : g_out
            localparam int CH = g / clk_sync_pkg::OUT_PER_CH;
            logic spd;
            logic cm;
            assign spd = out_cfg_r[g][clk_sync_pkg::OUT_PD]
                       | ch_ctl_r[CH][clk_sync_pkg::CH_PD] | ~pin_s_r[2];
            assign cm  = out_cfg_r[g][clk_sync_pkg::OUT_CMOS];
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    diff_q[g]    <= 1'b0;
                    diff_on[g]   <= 1'b0;
                    safe_pd[g]   <= 1'b1;
                    swing[g]     <= 2'b00;
                    cmos_a[g]    <= 1'b0;
                    cmos_b[g]    <= 1'b0;
                    cmos_a_oe[g] <= 1'b0;
                    cmos_b_oe[g] <= 1'b0;
                end else begin
                    diff_on[g]   <= ~cm & ~spd & ~total_pd;
                    safe_pd[g]   <= spd;
                    swing[g]     <= out_cfg_r[g][clk_sync_pkg::OUT_SWING_LO +: 2];
                    diff_q[g]    <= ~cm & ~spd & ~total_pd
                                  & (ch_lvl[CH] ^ out_cfg_r[g][clk_sync_pkg::OUT_INV_A]);
                    cmos_a_oe[g] <= cm & ~spd & out_cfg_r[g][clk_sync_pkg::OUT_EN_A];
                    cmos_b_oe[g] <= cm & ~spd & out_cfg_r[g][clk_sync_pkg::OUT_EN_B];
                    cmos_a[g]    <= cm & ~spd & out_cfg_r[g][clk_sync_pkg::OUT_EN_A]
                                  & (ch_lvl[CH] ^ out_cfg_r[g][clk_sync_pkg::OUT_INV_A]);
                    cmos_b[g]    <= cm & ~spd & out_cfg_r[g][clk_sync_pkg::OUT_EN_B]
                                  & (ch_lvl[CH] ^ out_cfg_r[g][clk_sync_pkg::OUT_INV_B]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            total_pd <= 1'b0;
        end else begin
            total_pd <= dist_act_r[clk_sync_pkg::DIST_PD];
        end
    end
endmodule : sync_dev
`default_nettype wire

// File: verilog/sync_host.sv
// host end: serial register writes, sync and reset pin pulses, sleep
`timescale 1ns/1ns
`default_nettype none
module sync_host (
    input  wire logic        clk,
    input  wire logic        rst_b,
    clk_sync_if.host         pins,
    input  wire logic        wr_valid,
    input  wire logic [15:0] wr_addr,
    input  wire logic [7:0]  wr_data,
    output logic             wr_ready,
    input  wire logic        sync_req,
    input  wire logic        reset_req,
    input  wire logic        sleep_req,
    input  wire logic        cfg_src_sel
);
    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_TAIL, H_PIN} hst_t;
    hst_t        st_r;
    logic [23:0] frame_r;
    logic [4:0]  bit_r;
    logic [1:0]  div_r;
    logic        en;
    logic        sclk_r;
    logic        csb_r;
    logic        sync_n_r;
    logic        reset_n_r;
    logic        sleep_n_r;
    logic        cfg_r;
    logic [3:0]  pin_cnt_r;

    assign en       = (div_r == 2'(clk_sync_pkg::SCLK_HALF_CYC - 1));
    assign wr_ready = (st_r == H_IDLE);

    always_ff @(posedge clk) begin
        if (!rst_b || st_r == H_IDLE) begin
            div_r <= 2'b00;
        end else begin
            div_r <= en ? 2'b00 : div_r + 2'b01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sleep_n_r <= 1'b1;
            cfg_r     <= 1'b0;
        end else begin
            sleep_n_r <= ~sleep_req;
            cfg_r     <= cfg_src_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r      <= H_IDLE;
            frame_r   <= 24'h000000;
            bit_r     <= 5'h00;
            sclk_r    <= 1'b0;
            csb_r     <= 1'b1;
            sync_n_r  <= 1'b1;
            reset_n_r <= 1'b1;
            pin_cnt_r <= 4'h0;
        end else begin
            case (st_r)
                H_IDLE: begin
                    if (wr_valid) begin
                        frame_r <= {wr_addr, wr_data};
                        bit_r   <= 5'h00;
                        csb_r   <= 1'b0;
                        st_r    <= H_SHIFT;
                    end else if (sync_req || reset_req) begin
                        sync_n_r  <= ~sync_req;
                        reset_n_r <= ~reset_req;
                        pin_cnt_r <= 4'(clk_sync_pkg::PIN_LOW_CYC - 1);
                        st_r      <= H_PIN;
                    end
                end
                H_SHIFT: begin
                    if (en) begin
                        sclk_r <= ~sclk_r;
                        if (sclk_r) begin
                            frame_r <= {frame_r[22:0], 1'b0};
                            if (bit_r == 5'(clk_sync_pkg::FRAME_BITS - 1)) begin
                                csb_r <= 1'b1;
                                st_r  <= H_TAIL;
                            end else begin
                                bit_r <= bit_r + 5'h01;
                            end
                        end
                    end
                end
                H_TAIL: begin
                    if (en) begin
                        sclk_r <= ~sclk_r;
                        if (sclk_r) begin
                            st_r <= H_IDLE;
                        end
                    end
                end
                H_PIN: begin
                    if (pin_cnt_r == 4'h0) begin
                        sync_n_r  <= 1'b1;
                        reset_n_r <= 1'b1;
                        st_r      <= H_IDLE;
                    end else begin
                        pin_cnt_r <= pin_cnt_r - 4'h1;
                    end
                end
                default: begin
                    st_r <= H_IDLE;
                end
            endcase
        end
    end

    assign pins.sclk        = sclk_r;
    assign pins.csb         = csb_r;
    assign pins.sdi         = frame_r[23];
    assign pins.sync_n      = sync_n_r;
    assign pins.reset_n     = reset_n_r;
    assign pins.sleep_pin_n = sleep_n_r;
    assign pins.cfg_src     = cfg_r;
endmodule : sync_host
`default_nettype wire
